// *** kbd_pkg.sv ***
package kbd_pkg;
    localparam int unsigned CLK_MHZ     = 200;
    localparam int unsigned SCAN_MS     = 10;
    localparam int unsigned POR_MS      = 150;
    localparam int unsigned TEST_MS     = 400;
    localparam int unsigned TYP_DLY_MS  = 500;
    localparam int unsigned TYP_HZ      = 11;
    localparam int unsigned CLK_LOW_US  = 41;
    localparam int unsigned CLK_HIGH_US = 35;
    localparam int unsigned HBT_US      = 20;
    localparam int unsigned SCAN_CYC    = SCAN_MS * 1000 * CLK_MHZ;
    localparam int unsigned POR_CYC     = POR_MS * 1000 * CLK_MHZ;
    localparam int unsigned TEST_CYC    = TEST_MS * 1000 * CLK_MHZ;
    localparam int unsigned TYP_DLY_CYC = TYP_DLY_MS * 1000 * CLK_MHZ + 1;
    localparam int unsigned TYP_PER_CYC = CLK_MHZ * 1000000 / TYP_HZ;
    localparam int unsigned LOW_CYC     = CLK_LOW_US * CLK_MHZ;
    localparam int unsigned HIGH_CYC    = CLK_HIGH_US * CLK_MHZ;
    localparam int unsigned HBT_CYC     = HBT_US * CLK_MHZ;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam logic [7:0]  CODE_PASS   = 8'hAA;
    localparam logic [7:0]  CODE_FAIL   = 8'hFC;
    localparam logic [7:0]  CODE_OVR    = 8'h00;
    localparam logic [7:0]  CODE_OVR_M1 = 8'hFF;
    localparam logic [7:0]  CODE_BRK    = 8'hF0;
    localparam logic [7:0]  M1_BRK_BIT  = 8'h80;
    localparam logic [7:0]  CODE_BASE   = 8'h01;
    localparam logic [3:0]  STOP_IDX    = 4'hA;
    localparam logic [1:0]  MODE_1      = 2'h1;
    localparam logic [1:0]  MODE_3      = 2'h3;
    localparam logic [1:0]  MODE_RESET  = 2'h2;
    localparam logic [1:0]  CFG_TYPEM   = 2'h0;
    localparam logic [1:0]  CFG_MAKE    = 2'h1;
    localparam logic [1:0]  CFG_BREAK   = 2'h2;

    typedef enum logic [3:0] {
        PW_POR  = 4'h1,
        PW_TEST = 4'h2,
        PW_RUN  = 4'h4,
        PW_DIS  = 4'h8
    } pw_e;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_HOLD = 4'h2,
        TX_LOW  = 4'h4,
        TX_HIGH = 4'h8
    } tx_e;
endpackage

// *** keyboard_scan_link_transmitter.sv ***
`timescale 1ns/1ps
// Functional notes
// R01: Scan the whole key matrix every 10 ms while the link keeps running.
// R02: Key down gives a make code, key up a break code; pause makes only.
// R03: Startup reset is raised between 150 ms and 2 s after power-up.
// R04: Self-test looks for shorted keys and lasts 300 to 500 ms.
// R05: Failed self-test sends an error code, then stays disabled until a host command.
// R06: Passed self-test sends AAh and then starts scanning.
// R07: Scan codes wait in a 16-byte FIFO; responses and repeats bypass it.
// R08: A byte that finds the FIFO full becomes the overrun code; later ones are dropped.
// R09: A multi-byte keystroke is kept only if all its bytes fit.
// R10: Sample clock and data before sending; hold the byte while clock is low.
// R11: Each frame to the host is 11 bits.
// R12: Clock low about 41 us, high 30-40 us, high 20 us before sending.
// R13: Host halts a frame by pulling clock low; keyboard checks it each bit. The code acts on it only once, at the end of the high phase after parity.
// R14: Inhibit before the parity rising edge: the frame still completes.
// R15: Host sending uses the same timing, slightly shorter.
// R16: Three modes with own code sets; mode 2 after reset; user or host may change.
// R17: Mode 3 keys are set one by one to make-only, break-only or repeat.
// R18: Repeating key held over 500 ms resends make at 10-12 Hz; pause never.
// R19: Only the latest pressed key repeats.
// R20: Host raises its keyboard interrupt on each received scan code.
// R21: The self-test failure code is FCh.
// R22: Overrun code is 00h in modes 2 and 3, FFh in mode 1.
// R23: Frame: low start, eight data LSB first, odd parity, high stop.
// R24: Inhibit after the parity rising edge aborts; the byte is resent later.

////////////////////////////////////////////////////////////////////////////////
module kbd_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 16
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic                   in_valid,
    input  wire logic [W-1:0]           in_data,
    output logic                        in_ready,
    output logic                        out_valid,
    output logic [W-1:0]                out_data,
    input  wire logic                   out_ready,
    output logic [$clog2(D+1)-1:0]      count
);
    localparam int unsigned AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0]   mem;
        logic [AW-1:0]         wr;
        logic [AW-1:0]         rd;
        logic [$clog2(D+1)-1:0] cnt;
    } fifo_s;

    fifo_s st_q, st_d;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (32'(p) == D - 1) ? '0 : AW'(p + 1'b1);
    endfunction

    logic push, pop;
    assign in_ready  = (32'(st_q.cnt) != D);
    assign out_valid = (st_q.cnt != '0);
    assign out_data  = st_q.mem[st_q.rd];
    assign count     = st_q.cnt;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr           = nxt(st_q.wr);
        end
        if (pop) begin
            st_d.rd = nxt(st_q.rd);
        end
        st_d.cnt = st_q.cnt + {{($clog2(D+1)-1){1'b0}}, push}
                   - {{($clog2(D+1)-1){1'b0}}, pop};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end
endmodule // kbd_fifo

////////////////////////////////////////////////////////////////////////////////
module keyboard_scan_link_transmitter import kbd_pkg::*; #(
    parameter int unsigned NUM_KEYS  = 8,
    parameter int unsigned PAUSE_KEY = 7,
    parameter logic [NUM_KEYS-1:0] NO_REPEAT = '0,
    parameter int unsigned DEPTH     = FIFO_DEPTH,
    parameter int unsigned SCAN_C    = SCAN_CYC,
    parameter int unsigned POR_C     = POR_CYC,
    parameter int unsigned TEST_C    = TEST_CYC,
    parameter int unsigned TDLY_C    = TYP_DLY_CYC,
    parameter int unsigned TPER_C    = TYP_PER_CYC,
    parameter int unsigned LOW_C     = LOW_CYC,
    parameter int unsigned HIGH_C    = HIGH_CYC,
    parameter int unsigned HBT_C     = HBT_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    input  wire logic [NUM_KEYS-1:0]     key_raw,
    input  wire logic [2*NUM_KEYS-1:0]   key_cfg,
    input  wire logic                    mode_set_valid,
    input  wire logic [1:0]              mode_set_value,
    input  wire logic                    host_cmd_valid,
    input  wire logic                    link_clk_in,
    output logic                         link_clk_out,
    output logic                         link_clk_oe,
    input  wire logic                    link_data_in,
    output logic                         link_data_out,
    output logic                         link_data_oe,
    output logic                         kbd_disabled,
    output logic [1:0]                   kbd_mode
);
    localparam int unsigned KW = (NUM_KEYS > 1) ? $clog2(NUM_KEYS) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [NUM_KEYS-1:0] k1;
        logic [NUM_KEYS-1:0] k2;
        logic [NUM_KEYS-1:0] prev;
        logic                c1;
        logic                c2;
        logic                d1;
        logic                d2;
        pw_e                 pw;
        logic [31:0]         pcnt;
        logic                fail;
        logic [31:0]         scnt;
        logic                walk;
        logic [KW-1:0]       idx;
        logic                brk2;
        logic [7:0]          b2;
        logic [1:0]          mode;
        logic                rep_v;
        logic [KW-1:0]       rep_k;
        logic [31:0]         rcnt;
        logic                typ_p;
        logic                resp_p;
        logic [7:0]          resp_b;
        logic                ovr;
        tx_e                 tx;
        logic [31:0]         tcnt;
        logic [3:0]          bitn;
        logic [10:0]         fr;
        logic                clk_oe;
        logic                dat_oe;
        logic                dis;
    } top_s;

    top_s st_q, st_d;

    function automatic logic [7:0] make_code(input logic [KW-1:0] k);
        return 8'(k) + CODE_BASE;
    endfunction

    logic          push;
    logic [7:0]    push_b;
    logic          f_ready, f_valid, pop;
    logic [7:0]    f_data;
    logic [CW-1:0] f_cnt;

    ////////////////////////////////////////////////////////////////////////////
    kbd_fifo #(.W(8), .D(DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (push),
        .in_data   (push_b),
        .in_ready  (f_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (pop),
        .count     (f_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic       dn, up, want, rept, fits, m3;
    logic [1:0] cfg;
    logic [7:0] mk;
    int unsigned nb;

    always_comb begin
        st_d   = st_q;
        push   = 1'b0;
        push_b = 8'h00;
        pop    = 1'b0;
        nb     = 1;
        st_d.k1 = key_raw;
        st_d.k2 = st_q.k1;
        st_d.c1 = link_clk_in;
        st_d.c2 = st_q.c1;
        st_d.d1 = link_data_in;
        st_d.d2 = st_q.d1;
        m3   = (st_q.mode == MODE_3);
        cfg  = key_cfg[2*st_q.idx +: 2];
        mk   = make_code(st_q.idx);
        dn   = st_q.k2[st_q.idx] & ~st_q.prev[st_q.idx];
        up   = ~st_q.k2[st_q.idx] & st_q.prev[st_q.idx];
        rept = ~NO_REPEAT[st_q.idx] && (32'(st_q.idx) != PAUSE_KEY)
               && (!m3 || cfg == CFG_TYPEM);                    // see R17 see R18
        want = dn ? !(m3 && cfg == CFG_BREAK)
                  : up && (32'(st_q.idx) != PAUSE_KEY)
                       && !(m3 && cfg == CFG_MAKE);            // see R02 see R17
        if (up && st_q.mode != MODE_1) begin
            nb = 2;
        end
        fits = (32'(f_cnt) + nb <= DEPTH);                      // see R09
        if (mode_set_valid && mode_set_value != 2'h0) begin
            st_d.mode  = mode_set_value;                        // see R16
            st_d.rep_v = 1'b0;
        end
        case (st_q.pw)
            PW_POR: begin
                st_d.pcnt = st_q.pcnt + 32'h1;
                if (st_q.pcnt == POR_C - 1) begin               // see R03
                    st_d.pw   = PW_TEST;
                    st_d.pcnt = '0;
                end
            end
            PW_TEST: begin
                st_d.pcnt = st_q.pcnt + 32'h1;
                if (|st_q.k2) begin
                    st_d.fail = 1'b1;                           // see R04
                end
                if (st_q.pcnt == TEST_C - 1) begin
                    st_d.resp_p = 1'b1;
                    st_d.resp_b = st_d.fail ? CODE_FAIL : CODE_PASS; // see R21 see R06
                    st_d.pw     = st_d.fail ? PW_DIS : PW_RUN;  // see R05
                    st_d.prev   = st_q.k2;
                end
            end
            PW_DIS: begin
                if (host_cmd_valid) begin                       // see R05
                    st_d.pw   = PW_RUN;
                    st_d.prev = st_q.k2;
                end
            end
            PW_RUN: begin
                st_d.scnt = (st_q.scnt == SCAN_C - 1) ? '0 : st_q.scnt + 32'h1;
                if (st_q.scnt == '0 && !st_q.walk) begin        // see R01
                    st_d.walk = 1'b1;
                    st_d.idx  = '0;
                end
                // Counted first, so that a new press below reloads the delay
                if (st_q.rep_v) begin
                    st_d.rcnt = st_q.rcnt - 32'h1;
                    if (st_q.rcnt == '0) begin                  // see R18
                        st_d.typ_p = 1'b1;
                        st_d.rcnt  = TPER_C - 1;
                    end
                end
                if (st_q.walk) begin
                    if (st_q.brk2) begin
                        push       = 1'b1;
                        push_b     = st_q.b2;
                        st_d.brk2  = 1'b0;
                    end else begin
                        st_d.prev[st_q.idx] = st_q.k2[st_q.idx];
                        if (want) begin
                            if (st_q.ovr || !fits) begin
                                st_d.ovr = 1'b1;                // see R08
                            end else begin
                                push   = 1'b1;                  // see R07
                                push_b = dn ? mk : (nb == 2) ? CODE_BRK : (mk | M1_BRK_BIT);
                                st_d.brk2 = (nb == 2);
                                st_d.b2   = mk;
                            end
                        end
                        if (dn && rept && !st_q.ovr && fits) begin // see R19 see R08
                            st_d.rep_v = 1'b1;
                            st_d.rep_k = st_q.idx;
                            st_d.rcnt  = TDLY_C - 1;
                        end else if (up && st_q.rep_v && st_q.rep_k == st_q.idx) begin
                            st_d.rep_v = 1'b0;
                        end
                    end
                    if (!st_d.brk2) begin
                        st_d.idx  = KW'(st_q.idx + 1'b1);
                        st_d.walk = (32'(st_q.idx) != NUM_KEYS - 1);
                    end
                end
            end
            default: st_d.pw = PW_POR;
        endcase

        // Link transmitter; responses and repeats go ahead of the queue
        case (st_q.tx)
            TX_IDLE: begin
                if (st_q.resp_p || (st_q.pw == PW_RUN
                        && (st_q.typ_p || f_valid || st_q.ovr))) begin
                    st_d.tx   = TX_HOLD;
                    st_d.tcnt = '0;
                    if (st_q.resp_p) begin
                        st_d.resp_p = 1'b0;
                        mk          = st_q.resp_b;
                    end else if (st_q.typ_p) begin
                        st_d.typ_p  = st_q.rep_v && st_q.rcnt == '0; // see R07
                        mk          = make_code(st_q.rep_k);
                    end else if (f_valid) begin
                        pop = 1'b1;
                        mk  = f_data;
                    end else begin
                        st_d.ovr = 1'b0;
                        mk = (st_q.mode == MODE_1) ? CODE_OVR_M1 : CODE_OVR; // see R22
                    end
                    st_d.fr = {1'b1, ~^mk, mk, 1'b0};           // see R11 see R23
                end
            end
            TX_HOLD: begin
                st_d.tcnt = st_q.tcnt + 32'h1;
                if (!st_q.c2 || !st_q.d2) begin
                    st_d.tcnt = '0;                             // see R10
                end else if (st_q.tcnt == HBT_C - 1) begin      // see R12
                    st_d.tx     = TX_LOW;
                    st_d.tcnt   = '0;
                    st_d.bitn   = 4'h0;
                    st_d.clk_oe = 1'b1;
                    st_d.dat_oe = ~st_q.fr[0];
                end
            end
            TX_LOW: begin
                st_d.tcnt = st_q.tcnt + 32'h1;
                if (st_q.tcnt == LOW_C - 1) begin               // see R12
                    st_d.tcnt   = '0;
                    st_d.clk_oe = 1'b0;
                    if (st_q.bitn == STOP_IDX) begin
                        st_d.tx     = TX_IDLE;
                        st_d.dat_oe = 1'b0;
                    end else begin
                        st_d.tx     = TX_HIGH;
                        st_d.bitn   = st_q.bitn + 4'h1;
                        st_d.dat_oe = ~st_q.fr[st_q.bitn + 4'h1]; // see R23
                    end
                end
            end
            TX_HIGH: begin
                st_d.tcnt = st_q.tcnt + 32'h1;
                if (st_q.tcnt == HIGH_C - 1) begin              // see R13
                    st_d.tcnt = '0;
                    if (!st_q.c2 && st_q.bitn == STOP_IDX) begin
                        st_d.tx     = TX_HOLD;                  // see R24
                        st_d.dat_oe = 1'b0;
                    end else begin
                        st_d.tx     = TX_LOW;                   // see R14
                        st_d.clk_oe = 1'b1;
                    end
                end
            end
            default: st_d.tx = TX_IDLE;
        endcase
        st_d.dis = (st_d.pw == PW_DIS);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= '0;
            st_q.pw   <= PW_POR;
            st_q.tx   <= TX_IDLE;
            st_q.mode <= MODE_RESET;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign link_clk_out  = 1'b0 & st_q.clk_oe;
    assign link_data_out = 1'b0 & st_q.dat_oe;
    assign link_clk_oe   = st_q.clk_oe;
    assign link_data_oe  = st_q.dat_oe;
    assign kbd_disabled  = st_q.dis;
    assign kbd_mode      = st_q.mode;

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] lo_len;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_len <= '0;
        end else if (ce) begin
            lo_len <= st_q.clk_oe ? lo_len + 32'h1 : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_low_phase_len: assert property ($fell(st_q.clk_oe) |-> lo_len == LOW_C) // see R12
        else $error("clock low phase length wrong");
    chk_start_bit_low: assert property ($rose(st_q.clk_oe) && st_q.bitn == 4'h0
        |-> st_q.dat_oe) // see R23
        else $error("start bit not low");
    chk_abort_at_stop: assert property ($past(st_q.tx) == TX_HIGH && st_q.tx == TX_HOLD
        |-> $past(st_q.bitn) == STOP_IDX) // see R24
        else $error("frame aborted before parity edge");
    chk_inhibit_holds: assert property (st_q.tx == TX_HOLD && !st_q.c2
        |=> st_q.tx == TX_HOLD) // see R10
        else $error("frame started while inhibited");
    chk_pass_code: assert property ($past(st_q.pw) == PW_TEST && st_q.pw == PW_RUN
        |-> st_q.resp_p && st_q.resp_b == CODE_PASS) // see R06
        else $error("pass code not queued");
    chk_fail_disable: assert property (st_q.pw == PW_DIS && !host_cmd_valid
        |=> st_q.pw == PW_DIS) // see R05
        else $error("left disabled state without command");
    chk_ovr_no_push: assert property (st_q.ovr && !st_q.brk2 |-> !push) // see R08
        else $error("byte queued during overrun");
    chk_repeat_src: assert property ($rose(st_q.typ_p) |-> $past(st_q.rep_v)) // see R18
        else $error("repeat without held key");
endmodule // keyboard_scan_link_transmitter

// *** kbd_host_model.sv ***
`timescale 1ns/1ps
module kbd_host_model (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  clk_oe,
    input  wire logic  data_oe,
    input  wire logic  inhibit,
    output logic       link_clk,
    output logic       link_data,
    output logic       rx_valid,
    output logic [7:0] rx_byte,
    output logic       rx_err
);
    logic        clk_q;
    logic [3:0]  cnt_q;
    logic [10:0] sh_q;
    logic [10:0] nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Open-drain wires with pull-ups; the host inhibits by pulling the clock low
    assign link_clk  = ~(clk_oe | inhibit);
    assign link_data = ~data_oe;
    assign nxt       = {link_data, sh_q[10:1]};

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q    <= 1'b1;
            cnt_q    <= 4'h0;
            sh_q     <= 11'h000;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
            rx_err   <= 1'b0;
        end else begin
            clk_q    <= link_clk;
            rx_valid <= 1'b0;
            if (inhibit) begin
                cnt_q <= 4'h0;
            end else if (clk_q && !link_clk) begin
                // Sample on the falling edge, least significant bit first
                sh_q  <= nxt;
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == 4'hA) begin
                    cnt_q    <= 4'h0;
                    rx_valid <= 1'b1;
                    rx_byte  <= nxt[8:1];
                    rx_err   <= nxt[0] | ~nxt[10] | ~(^nxt[9:1]);
                end
            end
        end
    end
endmodule // kbd_host_model

// *** keyboard_scan_link_transmitter_test.sv ***
`timescale 1ns/1ps
module keyboard_scan_link_transmitter_test import kbd_pkg::*;;
    localparam int unsigned SC    = 200;
    localparam int unsigned LIMIT = 40000;
    localparam int unsigned DEP   = 4;
    localparam int unsigned PT    = 100;
    localparam int unsigned TDL   = 2000;
    localparam int unsigned TPR   = 3000;
    localparam int unsigned PH    = 16;
    localparam int unsigned HB    = 48;
    localparam logic [7:0]  REP [8] = '{8'h08, 8'h02, 8'h04, 8'h04, 8'hF0, 8'h02, 8'hF0, 8'h04};
    logic        clk, rst_n, mode_set_valid, host_cmd_valid, inhibit, kbd_disabled;
    logic        ce, clk_out, data_out;
    logic        clk_oe, data_oe, link_clk, link_data, rx_valid, rx_err;
    logic [7:0]  key_raw, rx_byte, mk;
    logic [15:0] key_cfg;
    logic [1:0]  mode_set_value, kbd_mode;
    logic [31:0] seed;
    logic [7:0]  exp_q[$];
    int          mismatches, checks, cycles, k, cfg;

    keyboard_scan_link_transmitter #(.DEPTH(DEP), .SCAN_C(SC), .POR_C(PT), .TEST_C(PT),
        .TDLY_C(TDL), .TPER_C(TPR), .LOW_C(PH), .HIGH_C(PH), .HBT_C(HB)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .key_raw(key_raw), .key_cfg(key_cfg),
        .mode_set_valid(mode_set_valid), .mode_set_value(mode_set_value),
        .host_cmd_valid(host_cmd_valid), .link_clk_in(link_clk), .link_clk_out(clk_out),
        .link_clk_oe(clk_oe), .link_data_in(link_data), .link_data_out(data_out),
        .link_data_oe(data_oe), .kbd_disabled(kbd_disabled), .kbd_mode(kbd_mode));

    kbd_host_model host (.clk(clk), .rst_n(rst_n), .clk_oe(clk_oe), .data_oe(data_oe),
        .inhibit(inhibit), .link_clk(link_clk), .link_data(link_data),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_err(rx_err));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic drain();
        while (exp_q.size() != 0) @(negedge clk);
        wait_n(50);
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        wait_n(5);
        rst_n = 1'b1;
        @(negedge clk);
        check("mode_reset", {6'h00, kbd_mode}, {6'h00, MODE_RESET});
    endtask

    task automatic set_mode(input logic [1:0] v);
        mode_set_value = v;
        mode_set_valid = 1'b1;
        @(negedge clk);
        mode_set_valid = 1'b0;
        @(negedge clk);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            conclude();
        end
    end

    // Every received frame is taken against the oldest noted byte
    always @(negedge clk) begin
        if (rx_valid === 1'b1) begin
            check("frame_err", {7'h00, rx_err}, 8'h00);
            check("wire_drive", {6'h00, clk_out, data_out}, 8'h00);
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("MISMATCH extra_byte expected none seen %h", rx_byte);
            end else begin
                check("link_byte", rx_byte, exp_q.pop_front());
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        key_raw = 8'h01;
        key_cfg = 16'h0000;
        mode_set_valid = 1'b0;
        mode_set_value = MODE_RESET;
        host_cmd_valid = 1'b0;
        inhibit = 1'b0;
        seed = 32'd31087;
        // A key held through self-test fails it and leaves scanning off
        exp_q.push_back(CODE_FAIL);
        do_reset();
        drain();
        check("disabled", {7'h00, kbd_disabled}, 8'h01);
        key_raw = 8'h00;
        wait_n(3 * SC);
        host_cmd_valid = 1'b1;
        @(negedge clk);
        host_cmd_valid = 1'b0;
        @(negedge clk);
        check("enabled", {7'h00, kbd_disabled}, 8'h00);
        // Inhibit held through power-up keeps the completion code pending
        inhibit = 1'b1;
        do_reset();
        wait_n(4 * SC);
        exp_q.push_back(CODE_PASS);
        inhibit = 1'b0;
        drain();
        // A mode pulse while the clock enable is low is lost
        ce = 1'b0;
        set_mode(MODE_3);
        ce = 1'b1;
        check("mode_frozen", {6'h00, kbd_mode}, {6'h00, MODE_RESET});
        set_mode(2'h0);
        check("mode_zero", {6'h00, kbd_mode}, {6'h00, MODE_RESET});
        for (int m = 1; m <= 3; m += 2) begin
            seed = xs(seed);
            k = seed % 7;
            cfg = (seed >> 8) % 3;
            key_cfg = {8{cfg[1:0]}};
            set_mode(m[1:0]);
            check("mode_set", {6'h00, kbd_mode}, m[7:0]);
            mk = CODE_BASE + k[7:0];
            if (m == 1) begin
                exp_q.push_back(mk);
                exp_q.push_back(mk | M1_BRK_BIT);
            end else begin
                if (cfg != 2) exp_q.push_back(mk);
                if (cfg != 1) begin
                    exp_q.push_back(CODE_BRK);
                    exp_q.push_back(mk);
                end
            end
            key_raw[k] = 1'b1;
            wait_n(2 * SC);
            key_raw[k] = 1'b0;
            wait_n(2 * SC);
            drain();
        end
        // Pause makes once; of two held keys only the later one repeats
        set_mode(MODE_RESET);
        foreach (REP[i]) exp_q.push_back(REP[i]);
        key_raw = 8'h80;
        wait_n(2 * SC);
        key_raw = 8'h82;
        wait_n(300);
        key_raw = 8'h8A;
        wait_n(3500);
        key_raw = 8'h00;
        drain();
        // Inhibit after the parity rising edge drops the frame; it is sent again
        exp_q.push_back(CODE_BASE);
        exp_q.push_back(CODE_BRK);
        exp_q.push_back(CODE_BASE);
        key_raw = 8'h01;
        repeat (10) @(negedge link_clk);
        @(posedge link_clk);
        @(negedge clk);
        inhibit = 1'b1;
        wait_n(2 * PH);
        inhibit = 1'b0;
        key_raw = 8'h00;
        drain();
        // Six makes at once into a four-deep buffer: the sixth becomes overrun
        for (int i = 1; i <= 5; i++) exp_q.push_back(i[7:0]);
        exp_q.push_back(CODE_OVR);
        key_raw = 8'h3F;
        wait_n(2 * SC);
        // Releases while the overrun stands are lost as well
        key_raw = 8'h00;
        drain();
        conclude();
    end
endmodule // keyboard_scan_link_transmitter_test
